// ---- verilog/cfg_link_pkg.sv ----
// Overview of operation
// - Per channel, link fault is the OR of six receive conditions.
// - Fault output low when any condition holds, high only when none holds.
// - Received bit rate outside expected range is a fault condition.
// - Received amplitude below expected level is a fault condition.
// - Transition density below expected minimum is a fault condition.
// - Write strobe copies 8-bit data into latch chosen by 4-bit address.
// - Reset forces every configuration latch to its initialization value.
// - Local-clock force low locks recovery to reference clock, fault held low.
package cfg_link_pkg;
   localparam int NUM_CHANNELS = 4;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 8;
   localparam int NUM_LATCHES = 16;
   localparam int NUM_FAULT_CONDITIONS = 6;
   // initialization value of every latch; real per-field values are not modelled here
   localparam logic [7:0] LATCH_RESET_VALUE = 8'h00;
   // receive channel disable field position inside the per-channel latch
   localparam int RX_DISABLE_BIT = 0;
   // per-channel latch sits at address channel + this base
   localparam logic [3:0] CHANNEL_LATCH_BASE = 4'h0;
endpackage : cfg_link_pkg

// ---- verilog/fault_combine.sv ----
`timescale 1ns/1ps
`default_nettype none
module fault_combine (
   input wire logic rate_bad,
   input wire logic amplitude_low,
   input wire logic density_low,
   input wire logic rx_disabled,
   input wire logic local_clock_force_n,
   input wire logic reference_clock_missing,
   output logic link_fault_out_n,
   output logic lock_to_reference
);
   logic any_fault;

   always_comb begin
      any_fault = rate_bad
         | amplitude_low
         | density_low
         | rx_disabled
         | ~local_clock_force_n
         | reference_clock_missing;
      link_fault_out_n = ~any_fault;
      // recovery falls back to the reference whenever data cannot be trusted
      lock_to_reference = any_fault;
   end
endmodule : fault_combine
`default_nettype wire

// ---- verilog/config_link_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module config_link_top #(
   parameter int CHANNELS = cfg_link_pkg::NUM_CHANNELS
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic CONFIG_WRITE_STROBE_N,
   input wire logic [3:0] CONFIG_ADDR,
   input wire logic [7:0] CONFIG_DATA,
   input wire logic [CHANNELS-1:0] RATE_OUT_OF_RANGE,
   input wire logic [CHANNELS-1:0] AMPLITUDE_LOW,
   input wire logic [CHANNELS-1:0] DENSITY_LOW,
   input wire logic [CHANNELS-1:0] LOCAL_CLOCK_FORCE_N,
   input wire logic [CHANNELS-1:0] REFERENCE_CLOCK_MISSING,
   output logic [CHANNELS-1:0] LINK_FAULT_OUT_N,
   output logic [CHANNELS-1:0] LOCK_TO_REFERENCE,
   output logic [8*cfg_link_pkg::NUM_LATCHES-1:0] CONFIG_LATCHES
);
   logic [7:0] latch_q [cfg_link_pkg::NUM_LATCHES];
   logic [7:0] latch_d [cfg_link_pkg::NUM_LATCHES];
   logic strobe_q;
   logic strobe_d;
   logic write_edge;
   logic write_hit [cfg_link_pkg::NUM_LATCHES];

   // the strobe is level sensitive on the pins; one capture per low phase avoids
   // repeated loads while the host holds it down
   always_comb begin
      strobe_d = CONFIG_WRITE_STROBE_N;
      write_edge = strobe_q & ~CONFIG_WRITE_STROBE_N;
   end

   // reset parks the history at the idle level of the pulled-up strobe, so a strobe
   // that is high at release is never taken for a falling edge
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         strobe_q <= 1'b1;
      end else begin
         strobe_q <= strobe_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < cfg_link_pkg::NUM_LATCHES; g++) begin : g_latch
         // address decode per entry keeps each latch a plain enabled flop
         always_comb begin
            write_hit[g] = write_edge && (CONFIG_ADDR == 4'(g));
            latch_d[g] = latch_q[g];
            if (write_hit[g]) begin
               latch_d[g] = CONFIG_DATA;
            end
         end

         always_ff @(posedge CLOCK) begin
            if (SYS_RST) begin
               latch_q[g] <= cfg_link_pkg::LATCH_RESET_VALUE;
            end else begin
               latch_q[g] <= latch_d[g];
            end
         end

         assign CONFIG_LATCHES[8*g +: 8] = latch_q[g];

         // each entry loads only on its own address and clears on reset, writes or not
         a_entry_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            write_hit[g] |=> (latch_q[g] == $past(CONFIG_DATA)))
            else $error("addressed latch did not take the data");
         a_entry_keep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            !write_hit[g] |=> $stable(latch_q[g]))
            else $error("latch changed without its address");
         a_entry_init: assert property (@(posedge CLOCK)
            SYS_RST |=> (latch_q[g] == cfg_link_pkg::LATCH_RESET_VALUE))
            else $error("latch not initialized by reset");
      end
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         // the receive-disable bit lives in the channel's own latch
         localparam int rx_latch = int'(cfg_link_pkg::CHANNEL_LATCH_BASE) + g;
         fault_combine u_fault (
            .rate_bad(RATE_OUT_OF_RANGE[g]),
            .amplitude_low(AMPLITUDE_LOW[g]),
            .density_low(DENSITY_LOW[g]),
            .rx_disabled(latch_q[rx_latch][cfg_link_pkg::RX_DISABLE_BIT]),
            .local_clock_force_n(LOCAL_CLOCK_FORCE_N[g]),
            .reference_clock_missing(REFERENCE_CLOCK_MISSING[g]),
            .link_fault_out_n(LINK_FAULT_OUT_N[g]),
            .lock_to_reference(LOCK_TO_REFERENCE[g])
         );

         a_force_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            !LOCAL_CLOCK_FORCE_N[g] |-> (!LINK_FAULT_OUT_N[g] && LOCK_TO_REFERENCE[g]))
            else $error("forced local clock without fault");
         a_rate_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            RATE_OUT_OF_RANGE[g] |-> !LINK_FAULT_OUT_N[g])
            else $error("rate fault not shown");
         a_amp_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            AMPLITUDE_LOW[g] |-> !LINK_FAULT_OUT_N[g])
            else $error("amplitude fault not shown");
         a_density_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            DENSITY_LOW[g] |-> !LINK_FAULT_OUT_N[g])
            else $error("density fault not shown");
         a_fault_or: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            LINK_FAULT_OUT_N[g] == !(RATE_OUT_OF_RANGE[g] | AMPLITUDE_LOW[g] | DENSITY_LOW[g]
               | latch_q[rx_latch][cfg_link_pkg::RX_DISABLE_BIT] | !LOCAL_CLOCK_FORCE_N[g]
               | REFERENCE_CLOCK_MISSING[g]))
            else $error("fault output not the OR of conditions");
         a_clear_high: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            (LOCAL_CLOCK_FORCE_N[g] && !RATE_OUT_OF_RANGE[g] && !AMPLITUDE_LOW[g]
               && !DENSITY_LOW[g] && !REFERENCE_CLOCK_MISSING[g]
               && !latch_q[rx_latch][cfg_link_pkg::RX_DISABLE_BIT]) |-> LINK_FAULT_OUT_N[g])
            else $error("fault shown with no condition");
         a_disable_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            latch_q[rx_latch][cfg_link_pkg::RX_DISABLE_BIT] |-> !LINK_FAULT_OUT_N[g])
            else $error("disabled channel not shown as fault");
         a_refclk_fault: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            REFERENCE_CLOCK_MISSING[g] |-> !LINK_FAULT_OUT_N[g])
            else $error("missing reference not shown as fault");
         // recovery leaves the data stream whenever the channel reports a fault
         a_lock_match: assert property (@(posedge CLOCK) disable iff (SYS_RST)
            LOCK_TO_REFERENCE[g] == !LINK_FAULT_OUT_N[g])
            else $error("recovery source disagrees with fault output");
      end
   endgenerate

   // check helper: captures counted inside one low phase of the strobe, so an edge
   // detector that loaded again on a held strobe would show a count of two
   logic [1:0] phase_writes_q;
   logic [1:0] phase_writes_d;

   always_comb begin
      phase_writes_d = phase_writes_q;
      if (CONFIG_WRITE_STROBE_N) begin
         phase_writes_d = 2'h0;
      end else if (write_edge && (phase_writes_q != 2'h3)) begin
         phase_writes_d = phase_writes_q + 2'h1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         phase_writes_q <= 2'h0;
      end else begin
         phase_writes_q <= phase_writes_d;
      end
   end

   a_one_capture: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      phase_writes_q <= 2'h1)
      else $error("held strobe captured more than once");
   a_strobe_idle: assert property (@(posedge CLOCK)
      SYS_RST |=> strobe_q)
      else $error("strobe history not cleared by reset");

   a_write_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (strobe_q && !CONFIG_WRITE_STROBE_N) |=> (latch_q[$past(CONFIG_ADDR)] == $past(CONFIG_DATA)))
      else $error("write did not load latch");
   a_no_write_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !(strobe_q && !CONFIG_WRITE_STROBE_N) |=> $stable(CONFIG_LATCHES))
      else $error("latch changed without write");
   a_reset_init: assert property (@(posedge CLOCK)
      SYS_RST |=> (latch_q[0] == cfg_link_pkg::LATCH_RESET_VALUE
         && latch_q[15] == cfg_link_pkg::LATCH_RESET_VALUE))
      else $error("latches not initialized by reset");

   c_write: cover property (@(posedge CLOCK) disable iff (SYS_RST)
      strobe_q && !CONFIG_WRITE_STROBE_N);
   c_fault: cover property (@(posedge CLOCK) disable iff (SYS_RST) !LINK_FAULT_OUT_N[0]);
   c_clear: cover property (@(posedge CLOCK) disable iff (SYS_RST) LINK_FAULT_OUT_N[0]);
   c_force: cover property (@(posedge CLOCK) disable iff (SYS_RST) !LOCAL_CLOCK_FORCE_N[0]);
   c_reset_write: cover property (@(posedge CLOCK) SYS_RST && !CONFIG_WRITE_STROBE_N);
endmodule : config_link_top
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   output logic strobe_n,
   output logic [3:0] addr,
   output logic [7:0] data
);
   initial begin
      strobe_n = 1'b1;
      addr = 4'h0;
      data = 8'h00;
   end
   task automatic write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      strobe_n <= 1'b0;
      addr <= a;
      data <= d;
      @(posedge clk);
      strobe_n <= 1'b1;
      // released buses show junk, never the last value
      addr <= ~a;
      data <= ~d;
   endtask : write
endmodule : host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0, sys_rst = 1'b1, strobe_n;
   logic [3:0] addr, fault_n, lock, rate = '0, amp = '0, dens = '0, miss = '0, force_n = 4'hf;
   logic [7:0] data;
   logic [127:0] lat, exp_lat = '0;
   logic [127:0] q[$];
   int n_errors = 0, check_count = 0, cycles = 0;
   always #5 clock = ~clock;
   host_model i_host (.clk(clock), .strobe_n(strobe_n), .addr(addr), .data(data));
   config_link_top i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .CONFIG_WRITE_STROBE_N(strobe_n),
      .CONFIG_ADDR(addr), .CONFIG_DATA(data), .RATE_OUT_OF_RANGE(rate), .AMPLITUDE_LOW(amp),
      .DENSITY_LOW(dens), .LOCAL_CLOCK_FORCE_N(force_n), .REFERENCE_CLOCK_MISSING(miss),
      .LINK_FAULT_OUT_N(fault_n), .LOCK_TO_REFERENCE(lock), .CONFIG_LATCHES(lat));
   task automatic check(input logic [127:0] seen, input logic [127:0] want);
      check_count++;
      if (seen !== want) begin
         n_errors++;
         $display("Error at %0t: seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      // a write under reset must leave every latch at its init value
      if (!sys_rst) exp_lat[8*a+:8] = d;
      q.push_back(exp_lat);
      i_host.write(a, d);
   endtask : wr
   // sparse conditions, so fault-free channels still occur
   function automatic logic [3:0] sp();
      return 4'($urandom) & 4'($urandom);
   endfunction : sp
   always begin
      @(negedge strobe_n);
      @(posedge clock);
      #1 check(lat, q.pop_front());
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      logic [3:0] en, flt, frc, want_n;
      void'($urandom(90111));
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      // let the release settle so the first write's expectation sees reset low
      #1;
      for (int i = 0; i < 16; i++) wr(i[3:0], 8'($urandom));
      for (int i = 0; i < 200; i++) begin
         if (i % 6 == 0) wr(4'($urandom_range(3)), 8'($urandom));
         @(posedge clock);
         rate <= sp();
         amp <= sp();
         dens <= sp();
         miss <= sp();
         force_n <= ~sp();
         @(posedge clock);
         #1;
         for (int c = 0; c < 4; c++) en[c] = exp_lat[8*c];
         flt = rate | amp | dens | en | ~force_n | miss;
         frc = ~force_n;
         want_n = ~flt;
         check(fault_n, want_n);
         check(lock & frc, frc);
         check(lock, flt);
      end
      @(posedge clock);
      sys_rst <= 1'b1;
      exp_lat = '0;
      @(posedge clock);
      #1 check(lat, '0);
      wr(4'h5, 8'ha5);
      @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      wr(4'hf, 8'h3c);
      repeat (3) @(posedge clock);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
